// *** core/hapms_sequencer.sv ***
// Purpose: Power mode sequencer: deep sleep, hearing aid, warning, cradle.
// Assumes: Battery window comparators already apply hysteresis.
// Notes: Configuration stands in for OTP bits and is written over APB.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module hapms_sequencer
    import hapms_pkg::*;
#(
    parameter int unsigned WAKE_CYC = HAPMS_WAKE_CYC,
    parameter int unsigned SLEEP_CYC = HAPMS_SLEEP_CYC,
    parameter int unsigned HALF_SEC_CYC = HAPMS_HALF_SEC_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic button_sense_in,
    input wire logic sleep_request_in,
    input wire logic cradle_present,
    input wire logic battery_end_of_life,
    input wire logic vbat_above_1v1,
    input wire logic vbat_below_2v2,
    input wire logic vbat_above_3v0,
    output logic load_supply_out,
    output logic button_echo_out,
    output logic shutdown_warning_out,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    hapms_state_t state;
    hapms_state_t next_state;
    logic auto_on;
    logic lithium;
    logic [7:0] delay_cfg;
    logic [7:0] delay_cnt;
    logic [HAPMS_NEV-1:0] irq_stat;
    logic [HAPMS_NEV-1:0] irq_en;
    logic [HAPMS_NEV-1:0] events;
    logic button_held;
    logic sleep_held;
    logic half_tick;
    logic battery_ok;
    logic warn_load;
    logic wr_en;
    logic rd_en;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////
    hapms_hold_timer #(.COUNT(WAKE_CYC)) u_button_hold (
        .pclk(pclk),
        .presetn(presetn),
        .level(button_sense_in),
        .done(button_held)
    );

    // Deglitch: a short host pulse is dropped
    hapms_hold_timer #(.COUNT(SLEEP_CYC)) u_sleep_hold (
        .pclk(pclk),
        .presetn(presetn),
        .level(sleep_request_in),
        .done(sleep_held)
    );

    hapms_tick_gen #(.PERIOD(HALF_SEC_CYC)) u_half_sec (
        .pclk(pclk),
        .presetn(presetn),
        .restart(warn_load),
        .tick(half_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        if (lithium) begin
            battery_ok = vbat_above_3v0;
        end else begin
            battery_ok = vbat_above_1v1 && vbat_below_2v2;
        end
    end

    assign warn_load = (state != HAPMS_WARNING) && (next_state == HAPMS_WARNING);

    // Cradle wins over every other cause
    always_comb begin
        next_state = state;
        unique case (state)
            HAPMS_DEEP_SLEEP: begin
                if (cradle_present) begin
                    next_state = HAPMS_CRADLE;
                end else if (button_held && battery_ok) begin
                    next_state = HAPMS_HEARING;
                end
            end
            HAPMS_HEARING: begin
                if (cradle_present) begin
                    next_state = HAPMS_WARNING;
                end else if (battery_end_of_life) begin
                    next_state = HAPMS_DEEP_SLEEP;
                end else if (sleep_held) begin
                    next_state = HAPMS_DEEP_SLEEP;
                end
            end
            HAPMS_WARNING: begin
                if (!cradle_present) begin
                    next_state = HAPMS_HEARING;
                end else if (delay_cnt == 8'h00) begin
                    next_state = HAPMS_CRADLE;
                end
            end
            HAPMS_CRADLE: begin
                if (!cradle_present) begin
                    if (auto_on && battery_ok) begin
                        next_state = HAPMS_HEARING;
                    end else begin
                        next_state = HAPMS_DEEP_SLEEP;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= HAPMS_DEEP_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // Counter reaching zero means supply is cut next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_cnt <= HAPMS_DELAY_RST;
        end else if (warn_load) begin
            delay_cnt <= delay_cfg;
        end else if (state == HAPMS_WARNING && half_tick && delay_cnt != 8'h00) begin
            delay_cnt <= delay_cnt - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_supply_out <= 1'b0;
            button_echo_out <= 1'b0;
            shutdown_warning_out <= 1'b0;
        end else begin
            // Latched on; stays on after the wake pulse ends
            load_supply_out <= (next_state == HAPMS_HEARING) ||
                               (next_state == HAPMS_WARNING);
            button_echo_out <= (next_state == HAPMS_HEARING) && button_sense_in;
            shutdown_warning_out <= cradle_present;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        events = '0;
        events[HAPMS_EV_WAKE] = (state != HAPMS_HEARING) && (next_state == HAPMS_HEARING);
        events[HAPMS_EV_EOL] = (state == HAPMS_HEARING) && (next_state == HAPMS_DEEP_SLEEP)
                               && battery_end_of_life;
        events[HAPMS_EV_SLEEP] = (state == HAPMS_HEARING) && (next_state == HAPMS_DEEP_SLEEP)
                                 && !battery_end_of_life;
        events[HAPMS_EV_CRADLE] = warn_load;
        events[HAPMS_EV_OFF] = (state == HAPMS_WARNING) && (next_state == HAPMS_CRADLE);
    end

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_on <= 1'b0;
            lithium <= 1'b0;
            delay_cfg <= HAPMS_DELAY_RST;
            irq_en <= '0;
        end else if (wr_en && addr_hit(paddr, HAPMS_ADDR_CTRL)) begin
            auto_on <= pwdata[HAPMS_CTRL_AUTO_ON];
            lithium <= pwdata[HAPMS_CTRL_LITHIUM];
            // Zero is not a legal delay; a zero write keeps the previous delay
            if (pwdata[HAPMS_CTRL_DELAY_LSB +: 8] != 8'h00) begin
                delay_cfg <= pwdata[HAPMS_CTRL_DELAY_LSB +: 8];
            end
        end else if (wr_en && addr_hit(paddr, HAPMS_ADDR_IRQ_EN)) begin
            irq_en <= pwdata[HAPMS_NEV-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (wr_en && addr_hit(paddr, HAPMS_ADDR_IRQ_CLR)) begin
            irq_stat <= (irq_stat & ~pwdata[HAPMS_NEV-1:0]) | events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat | events) & irq_en);
        end
    end

    // Read data captured in setup; access always completes in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable &&
                       !(addr_hit(paddr, HAPMS_ADDR_CTRL) || addr_hit(paddr, HAPMS_ADDR_STATUS) ||
                         addr_hit(paddr, HAPMS_ADDR_IRQ_STAT) ||
                         addr_hit(paddr, HAPMS_ADDR_IRQ_CLR) ||
                         addr_hit(paddr, HAPMS_ADDR_IRQ_EN));
            if (rd_en) begin
                prdata <= '0;
                if (addr_hit(paddr, HAPMS_ADDR_CTRL)) begin
                    prdata[HAPMS_CTRL_AUTO_ON] <= auto_on;
                    prdata[HAPMS_CTRL_LITHIUM] <= lithium;
                    prdata[HAPMS_CTRL_DELAY_LSB +: 8] <= delay_cfg;
                end else if (addr_hit(paddr, HAPMS_ADDR_STATUS)) begin
                    prdata[3:0] <= state;
                    prdata[15:8] <= delay_cnt;
                    prdata[16] <= load_supply_out;
                end else if (addr_hit(paddr, HAPMS_ADDR_IRQ_STAT)) begin
                    prdata[HAPMS_NEV-1:0] <= irq_stat;
                end else if (addr_hit(paddr, HAPMS_ADDR_IRQ_EN)) begin
                    prdata[HAPMS_NEV-1:0] <= irq_en;
                end
            end
        end
    end
endmodule : hapms_sequencer

// *** core/hapms_pkg.sv ***
// Purpose: Constants for the hearing aid power mode sequencer.
// Assumes: pclk at 100 MHz; battery comparators arrive as levels; OTP bits are stood in for by APB register bits.
// Notes: Register map is reached over APB; one word per register.
package hapms_pkg;
    localparam int unsigned HAPMS_CLK_HZ = 100_000_000;
    localparam int unsigned HAPMS_WAKE_MS = 20;
    localparam int unsigned HAPMS_WAKE_CYC = HAPMS_CLK_HZ / 1000 * HAPMS_WAKE_MS;
    localparam int unsigned HAPMS_SLEEP_US = 100;
    localparam int unsigned HAPMS_SLEEP_CYC = HAPMS_CLK_HZ / 1_000_000 * HAPMS_SLEEP_US + 1;
    localparam int unsigned HAPMS_HALF_SEC_MS = 500;
    localparam int unsigned HAPMS_HALF_SEC_CYC = HAPMS_CLK_HZ / 1000 * HAPMS_HALF_SEC_MS;
    localparam logic [7:0] HAPMS_DELAY_RST = 8'h01;

    localparam logic [11:0] HAPMS_ADDR_CTRL = 12'h000;
    localparam logic [11:0] HAPMS_ADDR_STATUS = 12'h004;
    localparam logic [11:0] HAPMS_ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] HAPMS_ADDR_IRQ_CLR = 12'h00c;
    localparam logic [11:0] HAPMS_ADDR_IRQ_EN = 12'h010;

    localparam int unsigned HAPMS_CTRL_AUTO_ON = 0;
    localparam int unsigned HAPMS_CTRL_LITHIUM = 1;
    localparam int unsigned HAPMS_CTRL_DELAY_LSB = 8;

    localparam int unsigned HAPMS_EV_WAKE = 0;
    localparam int unsigned HAPMS_EV_EOL = 1;
    localparam int unsigned HAPMS_EV_SLEEP = 2;
    localparam int unsigned HAPMS_EV_CRADLE = 3;
    localparam int unsigned HAPMS_EV_OFF = 4;
    localparam int unsigned HAPMS_NEV = 5;

    typedef enum logic [3:0] {
        HAPMS_DEEP_SLEEP = 4'b0001,
        HAPMS_HEARING = 4'b0010,
        HAPMS_WARNING = 4'b0100,
        HAPMS_CRADLE = 4'b1000
    } hapms_state_t;
endpackage : hapms_pkg

// *** core/hapms_hold_timer.sv ***
// Purpose: Counts how long a level has stayed high without a break.
// Assumes: Input synchronous to pclk.
// Notes: done stays high while the level holds past the count.
`timescale 1ns/1ns
module hapms_hold_timer
    import hapms_pkg::*;
#(
    parameter int unsigned COUNT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic done
);
    localparam int unsigned W = $clog2(COUNT + 1);
    logic [W-1:0] cnt;

    // Any low cycle restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (!level) begin
            cnt <= '0;
        end else if (cnt != W'(COUNT)) begin
            cnt <= cnt + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= level && (cnt >= W'(COUNT - 1));
        end
    end
endmodule : hapms_hold_timer

// *** core/hapms_tick_gen.sv ***
// Purpose: Half-second tick generator for the warning delay.
// Assumes: Restarted whenever a new delay is loaded.
// Notes: tick is a one-cycle pulse.
`timescale 1ns/1ns
module hapms_tick_gen
    import hapms_pkg::*;
#(
    parameter int unsigned PERIOD = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    output logic tick
);
    localparam int unsigned W = $clog2(PERIOD + 1);
    logic [W-1:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (restart || cnt == W'(PERIOD - 1)) begin
            cnt <= '0;
            tick <= !restart;
        end else begin
            cnt <= cnt + W'(1);
            tick <= 1'b0;
        end
    end
endmodule : hapms_tick_gen

// *** dv/hapms_sequencer_assertions.sv ***
// Purpose: Port-level checks for the power mode sequencer.
// Assumes: Short counts from the bench; button and sleep run counters saturate at 255, cradle low at 15.
// Notes: Wake check is only meaningful while WAKE_CYC stays at or below 255.
`timescale 1ns/1ns
module hapms_sequencer_assertions
    import hapms_pkg::*;
#(
    parameter int unsigned WAKE_CYC = 20,
    parameter int unsigned SLEEP_CYC = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic button_sense_in,
    input wire logic sleep_request_in,
    input wire logic cradle_present,
    input wire logic battery_end_of_life,
    input wire logic load_supply_out,
    input wire logic button_echo_out,
    input wire logic shutdown_warning_out
);
    logic [7:0] bh;
    logic [7:0] sh;
    logic [3:0] cl;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // Run lengths: button high, sleep high, cradle low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bh <= 8'h00;
            sh <= 8'h00;
            cl <= 4'h0;
        end else begin
            bh <= !button_sense_in ? 8'h00 : bh + {7'h0, bh != 8'hff};
            sh <= !sleep_request_in ? 8'h00 : sh + {7'h0, sh != 8'hff};
            cl <= cradle_present ? 4'h0 : cl + {3'h0, cl != 4'hf};
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence off_soon_s;
        ##[0:3] !load_supply_out;
    endsequence
    AST_APB_READY: assert property (setup_s |=> pready ##1 !pready)
        else $error("pready not a one cycle answer");
    AST_APB_UNMAP: assert property (psel && !penable && paddr > 12'h010 |=> pready && pslverr)
        else $error("unmapped access without pslverr");
    AST_ECHO: assert property ($past(button_sense_in && load_supply_out &&
        !shutdown_warning_out) |-> button_echo_out)
        else $error("button echo missing");
    AST_WARN: assert property (shutdown_warning_out == $past(cradle_present))
        else $error("warning does not follow cradle");
    AST_CRADLE_OFF: assert property (cradle_present && !load_supply_out |=>
        !load_supply_out)
        else $error("supply on in cradle");
    AST_WAKE: assert property ($rose(load_supply_out) && cl > 4'h4 |-> bh >= WAKE_CYC)
        else $error("wake without full button hold");
    AST_EOL: assert property (battery_end_of_life && load_supply_out &&
        !cradle_present && !shutdown_warning_out |-> ##[1:3] !load_supply_out)
        else $error("supply kept on at end of life");
    AST_SLEEP_SHORT: assert property ($fell(load_supply_out) &&
        !$past(shutdown_warning_out) && !$past(battery_end_of_life) |->
        $past(sh) >= SLEEP_CYC - 1)
        else $error("short sleep request accepted");
    AST_SLEEP_ACT: assert property (sh == SLEEP_CYC + 2 && !cradle_present &&
        !shutdown_warning_out |-> off_soon_s)
        else $error("held sleep request not acted on");
    AST_LATCH: assert property (load_supply_out && !button_sense_in &&
        !cradle_present && !shutdown_warning_out && !battery_end_of_life &&
        !sleep_request_in && !$past(sleep_request_in) && !$past(sleep_request_in, 2) |=>
        load_supply_out)
        else $error("supply dropped without cause");
endmodule : hapms_sequencer_assertions

// *** dv/hapms_host_model.sv ***
// Purpose: Host processor model at the far side of the sequencer.
// Assumes: Host ignores the echo until it has booted for 16 cycles.
// Notes: hold_len sets the length of each sleep request in cycles.
`timescale 1ns/1ns
module hapms_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic button_echo_out,
    input wire logic load_supply_out,
    input wire logic low_batt,
    input wire logic [7:0] hold_len,
    output logic sleep_request_in
);
    logic [7:0] left;
    logic [4:0] up;
    logic echo_d;
    ////////////////////////////////////////////////////////////////////////////
    // Boot wait stops the wake press itself from switching us off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 8'h00;
            up <= 5'h00;
            echo_d <= 1'b0;
        end else begin
            echo_d <= button_echo_out;
            up <= !load_supply_out ? 5'h00 : up + {4'h0, !up[4]};
            if (button_echo_out && !echo_d && up[4]) begin
                left <= hold_len;
            end else if (low_batt && load_supply_out && left == 8'h00) begin
                left <= hold_len;
            end else if (left != 8'h00) begin
                left <= left - 8'h01;
            end
        end
    end
    // Released line sits at its pull-down level
    assign sleep_request_in = (left != 8'h00);
endmodule : hapms_host_model

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the power mode sequencer.
// Assumes: Wake 20, sleep 5 and half second 10 cycles.
// Notes: Outputs are read just after a rising edge, before that edge updates them.
`timescale 1ns/1ns
module tb;
    import hapms_pkg::*;
    localparam int unsigned W = 20;
    localparam int unsigned S = 5;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, load_supply_out, button_echo_out, shutdown_warning_out, irq;
    logic sleep_request_in, button_sense_in = 1'b0, cradle_present = 1'b0, low_batt = 1'b0;
    logic battery_end_of_life = 1'b0, vbat_above_1v1 = 1'b0, vbat_below_2v2 = 1'b0;
    logic vbat_above_3v0 = 1'b0;
    logic [7:0] hold_len = 8'h08;
    // Lithium, 1v1, 2v2, 3v0, long press, expected supply
    logic [5:0] tbl [6] = '{6'b011000, 6'b001010, 6'b010010, 6'b011011, 6'b111010, 6'b110111};
    int n_errors = 0, samples_checked = 0, k;
    always #5 pclk = ~pclk;
    hapms_sequencer #(.WAKE_CYC(W), .SLEEP_CYC(S), .HALF_SEC_CYC(10)) i_hapms_sequencer (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .button_sense_in, .sleep_request_in, .cradle_present, .battery_end_of_life,
        .vbat_above_1v1, .vbat_below_2v2, .vbat_above_3v0, .load_supply_out,
        .button_echo_out, .shutdown_warning_out, .irq);
    hapms_host_model i_hapms_host_model (.pclk, .presetn, .button_echo_out,
        .load_supply_out, .low_batt, .hold_len, .sleep_request_in);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            $display("Error at %0t ns: got %h expected %h", $time, g, x);
            n_errors++;
        end
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        @(posedge pclk);
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic press(input int n);
        @(posedge pclk);
        button_sense_in <= 1'b1;
        cyc(n);
        button_sense_in <= 1'b0;
    endtask : press
    task automatic see(input logic [31:0] g, input logic [31:0] x);
        chk(g, x);
    endtask : see
    task automatic wsup(input logic v, input int n);
        int i;
        for (i = 0; i < n && load_supply_out !== v; i++) @(posedge pclk);
        see({31'h0, load_supply_out}, {31'h0, v});
        if (load_supply_out !== v)
            results();
    endtask : wsup
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        presetn <= 1'b1;
        rd(HAPMS_ADDR_STATUS, 32'h1000f, 32'h1);
        rd(HAPMS_ADDR_CTRL, 32'hffff, 32'h100);
        xfer(1'b1, HAPMS_ADDR_IRQ_EN, 32'h1);
        for (k = 0; k < 6; k++) begin
            xfer(1'b1, HAPMS_ADDR_CTRL, {16'h0, 8'h01, 6'h0, tbl[k][5], 1'b0});
            {vbat_above_1v1, vbat_below_2v2, vbat_above_3v0} <= tbl[k][4:2];
            press(tbl[k][1] ? W + 10 : W - 2);
            cyc(10);
            see({31'h0, load_supply_out}, {31'h0, tbl[k][0]});
            if (tbl[k][0]) begin
                rd(HAPMS_ADDR_STATUS, 32'hf, 32'h2);
                press(3);
                see({31'h0, button_echo_out}, 32'h1);
                wsup(1'b0, 60);
            end
        end
        see({31'h0, irq}, 32'h1);
        rd(HAPMS_ADDR_IRQ_STAT, 32'h5, 32'h5);
        xfer(1'b1, HAPMS_ADDR_IRQ_EN, 32'h0);
        // irq is registered one cycle behind the register write
        cyc(1);
        repeat (2) begin
            cyc(1);
            see({31'h0, irq}, 32'h0);
        end
        xfer(1'b1, HAPMS_ADDR_IRQ_EN, 32'h1);
        xfer(1'b1, HAPMS_ADDR_IRQ_CLR, 32'h1f);
        cyc(1);
        repeat (2) begin
            cyc(1);
            see({31'h0, irq}, 32'h0);
        end
        rd(HAPMS_ADDR_IRQ_STAT, 32'h1f, 32'h0);
        rd(HAPMS_ADDR_IRQ_CLR, 32'hffffffff, 32'h0);
        xfer(1'b1, 12'h020, 32'h1);
        chk({31'h0, e}, 32'h1);
        // Zinc battery, auto on, two half-second steps of warning
        xfer(1'b1, HAPMS_ADDR_CTRL, 32'h0201);
        {vbat_above_1v1, vbat_below_2v2, vbat_above_3v0} <= 3'b110;
        press(W + 10);
        wsup(1'b1, 20);
        hold_len <= 8'(S - 2);
        low_batt <= 1'b1;
        cyc(40);
        low_batt <= 1'b0;
        see({31'h0, load_supply_out}, 32'h1);
        battery_end_of_life <= 1'b1;
        wsup(1'b0, 5);
        rd(HAPMS_ADDR_STATUS, 32'hf, 32'h1);
        battery_end_of_life <= 1'b0;
        cradle_present <= 1'b1;
        cyc(3);
        rd(HAPMS_ADDR_STATUS, 32'h1000f, 32'h8);
        cradle_present <= 1'b0;
        wsup(1'b1, 10);
        rd(HAPMS_ADDR_STATUS, 32'hf, 32'h2);
        hold_len <= 8'(S + 3);
        cradle_present <= 1'b1;
        cyc(2);
        see({31'h0, shutdown_warning_out}, 32'h1);
        low_batt <= 1'b1;
        rd(HAPMS_ADDR_STATUS, 32'h1000f, 32'h10004);
        cyc(10);
        see({31'h0, load_supply_out}, 32'h1);
        wsup(1'b0, 30);
        low_batt <= 1'b0;
        rd(HAPMS_ADDR_STATUS, 32'h1000f, 32'h8);
        xfer(1'b1, HAPMS_ADDR_CTRL, 32'h0200);
        cradle_present <= 1'b0;
        cyc(5);
        rd(HAPMS_ADDR_STATUS, 32'h1000f, 32'h1);
        presetn <= 1'b0;
        cyc(3);
        presetn <= 1'b1;
        rd(HAPMS_ADDR_CTRL, 32'hffff, 32'h100);
        results();
    end
endmodule : tb
bind hapms_sequencer hapms_sequencer_assertions #(.WAKE_CYC(WAKE_CYC), .SLEEP_CYC(SLEEP_CYC))
    i_hapms_sequencer_assertions (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .button_sense_in, .sleep_request_in, .cradle_present, .battery_end_of_life,
    .load_supply_out, .button_echo_out, .shutdown_warning_out);
